// ===== pcsr_map.svh
`ifndef PCSR_MAP_SVH
`define PCSR_MAP_SVH

// ----------------------------------------------------------------------
// Bus codes
// ----------------------------------------------------------------------
`define PCSR_ADDR_WR 8'hA4
`define PCSR_ADDR_RD 8'hA5
`define PCSR_REG_OFFSET 8'hFF
`define PCSR_CMD_SET_WEL 8'h02
`define PCSR_CMD_CLR_WEL 8'h00
`define PCSR_CMD_SET_REGISTER_WRITE_UNLOCK 8'h06
`define PCSR_BYTE_BITS 4'h8

// ----------------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------------
`define PCSR_BIT_MON2 6
`define PCSR_BIT_MON3 5
`define PCSR_BIT_LOCK 3
`define PCSR_BIT_REGISTER_WRITE_UNLOCK 2
`define PCSR_BIT_WEL 1
`define PCSR_RSVD_MASK 8'h91
`define PCSR_REG_RESET 8'h00
`define PCSR_PINS_IDLE 5'h18

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCSR_CLK_NS 10
`define PCSR_NV_TIME_US 5000
`define PCSR_NV_W 19
`endif

// ===== pcsr_pkg.sv
package pcsr_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    pcsr_st_idle = 4'h0,
    pcsr_st_addr = 4'h1,
    pcsr_st_ack = 4'h3,
    pcsr_st_sub = 4'h2,
    pcsr_st_data = 4'h6,
    pcsr_st_read = 4'h7,
    pcsr_st_wait = 4'h5
  } pcsr_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [1:0] mon;
  } pcsr_pins_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } pcsr_evt_s;

  typedef struct packed {
    pcsr_pins_s s1;
    pcsr_pins_s s2;
    logic scl_prev;
    logic sda_prev;
  } pcsr_front_s;

  typedef struct packed {
    pcsr_state_e state;
    pcsr_state_e nxt;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic sda_drive;
    logic ptr_ok;
    logic pending;
    logic [7:0] pend;
    logic global_write_latch;
    logic register_write_unlock;
    logic lock;
    logic nv_data;
    logic [1:0] flags;
    logic [18:0] nv_cnt;
    logic nv_store;
    logic [7:0] view;
    logic vol_ok;
    logic nv_ok;
  } pcsr_core_s;

endpackage : pcsr_pkg

// ===== pcsr_pin_front.sv
`timescale 1ns/1ns
`include "pcsr_map.svh"
module pcsr_pin_front (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic wp_pin,
  input wire logic [1:0] mon_pin,
  output pcsr_pkg::pcsr_pins_s pins,
  output pcsr_pkg::pcsr_evt_s evt
);

  // --------------------------------------------------------------------
  // Two-stage synchroniser and bus edge detection
  // --------------------------------------------------------------------
  pcsr_pkg::pcsr_front_s q;
  pcsr_pkg::pcsr_front_s d;

  // Edges are taken only from the second stage so that the first stage
  // never feeds any decision.
  always_comb begin
    d = q;
    d.s1 = {scl_pin, sda_pin, wp_pin, mon_pin};
    d.s2 = q.s1;
    d.scl_prev = q.s2.scl;
    d.sda_prev = q.s2.sda;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q.s1 <= `PCSR_PINS_IDLE;
      q.s2 <= `PCSR_PINS_IDLE;
      q.scl_prev <= 1'h1;
      q.sda_prev <= 1'h1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pins = q.s2;
  assign evt.start = q.scl_prev & q.s2.scl & q.sda_prev & ~q.s2.sda;
  assign evt.stop = q.scl_prev & q.s2.scl & ~q.sda_prev & q.s2.sda;
  assign evt.rise = ~q.scl_prev & q.s2.scl;
  assign evt.fall = q.scl_prev & ~q.s2.scl;

endmodule : pcsr_pin_front

// ===== pcsr_control_status.sv
`timescale 1ns/1ns
`include "pcsr_map.svh"
module pcsr_control_status #(
  parameter int NV_CYCLES = (`PCSR_NV_TIME_US * 1000) / `PCSR_CLK_NS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic wp_pin,
  input wire logic [1:0] monitor_reset_out,
  input wire logic nv_lock_recall,
  output logic [7:0] control_status,
  output logic pot_volatile_write_ok,
  output logic pot_nonvolatile_write_ok,
  output logic nv_store_pulse,
  output logic nv_store_data,
  output logic nv_busy
);

  // --------------------------------------------------------------------
  // Pin front end
  // --------------------------------------------------------------------
  pcsr_pkg::pcsr_pins_s pins;
  pcsr_pkg::pcsr_evt_s evt;
  pcsr_pkg::pcsr_core_s q;
  pcsr_pkg::pcsr_core_s d;
  logic busy;

  pcsr_pin_front u_front (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .wp_pin(wp_pin),
    .mon_pin(monitor_reset_out),
    .pins(pins),
    .evt(evt)
  );

  assign busy = q.nv_cnt != '0;

  // --------------------------------------------------------------------
  // Data byte acceptance
  // --------------------------------------------------------------------
  // With the unlock bit clear, a protect pin blocks everything but the latch-only
  // values, so the latch can still be managed for volatile pot access.
  function automatic logic pcsr_accept(input logic [7:0] b,
                                       input logic global_write_latch,
                                       input logic register_write_unlock,
                                       input logic wp);
    return register_write_unlock ? (global_write_latch & ~wp & ((b & `PCSR_RSVD_MASK) == `PCSR_REG_RESET))
                : ((b == `PCSR_CMD_SET_WEL) | (b == `PCSR_CMD_CLR_WEL) |
                   (global_write_latch & ~wp & (b == `PCSR_CMD_SET_REGISTER_WRITE_UNLOCK)));
  endfunction : pcsr_accept

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    d = q;
    d.nv_store = 1'h0;
    if (busy) begin
      d.nv_cnt = q.nv_cnt - `PCSR_NV_W'(1);
      if (q.nv_cnt == `PCSR_NV_W'(1)) begin
        d.lock = q.nv_data;
        d.nv_store = 1'h1;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (!pins.mon[i]) begin
        d.flags[i] = 1'h0;
      end
    end
    if (evt.start) begin
      d.state = pcsr_pkg::pcsr_st_addr;
      d.cnt = '0;
      d.sda_drive = 1'h0;
      d.pending = 1'h0;
    end else if (evt.stop) begin
      if (q.pending) begin
        if (!q.register_write_unlock) begin
          if (q.pend == `PCSR_CMD_SET_WEL) begin
            d.global_write_latch = 1'h1;
          end else if (q.pend == `PCSR_CMD_CLR_WEL) begin
            d.global_write_latch = 1'h0;
          end else begin
            d.global_write_latch = 1'h1;
            d.register_write_unlock = 1'h1;
          end
        end else begin
          for (int i = 0; i < 2; i++) begin
            d.flags[i] = q.pend[`PCSR_BIT_MON3 + i] & pins.mon[i];
          end
          d.global_write_latch = q.pend[`PCSR_BIT_WEL];
          if (!q.pend[`PCSR_BIT_REGISTER_WRITE_UNLOCK]) begin
            d.register_write_unlock = 1'h0;
            if (!pins.wp) begin
              d.nv_cnt = `PCSR_NV_W'(NV_CYCLES);
              d.nv_data = q.pend[`PCSR_BIT_LOCK];
            end
          end
        end
      end
      d.pending = 1'h0;
      d.ptr_ok = 1'h0;
      d.state = pcsr_pkg::pcsr_st_idle;
      d.sda_drive = 1'h0;
    end else if (evt.rise) begin
      if ((q.state == pcsr_pkg::pcsr_st_addr ||
           q.state == pcsr_pkg::pcsr_st_sub ||
           q.state == pcsr_pkg::pcsr_st_data) &&
          q.cnt != `PCSR_BYTE_BITS) begin
        d.shreg = {q.shreg[6:0], pins.sda};
        d.cnt = q.cnt + 4'h1;
      end
    end else if (evt.fall) begin
      case (q.state)
        pcsr_pkg::pcsr_st_addr: begin
          if (q.cnt == `PCSR_BYTE_BITS) begin
            d.cnt = '0;
            d.state = pcsr_pkg::pcsr_st_wait;
            d.ptr_ok = 1'h0;
            if (!busy && q.shreg == `PCSR_ADDR_WR) begin
              d.sda_drive = 1'h1;
              d.state = pcsr_pkg::pcsr_st_ack;
              d.nxt = pcsr_pkg::pcsr_st_sub;
            end else if (!busy && q.ptr_ok &&
                         q.shreg == `PCSR_ADDR_RD) begin
              d.sda_drive = 1'h1;
              d.state = pcsr_pkg::pcsr_st_ack;
              d.nxt = pcsr_pkg::pcsr_st_read;
            end
          end
        end
        pcsr_pkg::pcsr_st_sub: begin
          if (q.cnt == `PCSR_BYTE_BITS) begin
            d.cnt = '0;
            d.state = pcsr_pkg::pcsr_st_wait;
            if (q.shreg == `PCSR_REG_OFFSET) begin
              d.ptr_ok = 1'h1;
              d.sda_drive = 1'h1;
              d.state = pcsr_pkg::pcsr_st_ack;
              d.nxt = pcsr_pkg::pcsr_st_data;
            end
          end
        end
        pcsr_pkg::pcsr_st_data: begin
          if (q.cnt == `PCSR_BYTE_BITS) begin
            d.cnt = '0;
            d.state = pcsr_pkg::pcsr_st_wait;
            d.pending = 1'h0;
            if (!q.pending &&
                pcsr_accept(q.shreg, q.global_write_latch, q.register_write_unlock, pins.wp)) begin
              d.pending = 1'h1;
              d.pend = q.shreg;
              d.sda_drive = 1'h1;
              d.state = pcsr_pkg::pcsr_st_ack;
              d.nxt = pcsr_pkg::pcsr_st_data;
            end
          end
        end
        pcsr_pkg::pcsr_st_ack: begin
          if (q.nxt == pcsr_pkg::pcsr_st_read) begin
            d.shreg = {q.view[6:0], 1'h0};
            d.sda_drive = ~q.view[7];
            d.cnt = 4'h1;
            d.state = pcsr_pkg::pcsr_st_read;
          end else begin
            d.sda_drive = 1'h0;
            d.cnt = '0;
            d.state = q.nxt;
          end
        end
        pcsr_pkg::pcsr_st_read: begin
          if (q.cnt == `PCSR_BYTE_BITS) begin
            d.sda_drive = 1'h0;
            d.cnt = '0;
            d.state = pcsr_pkg::pcsr_st_wait;
          end else begin
            d.sda_drive = ~q.shreg[7];
            d.shreg = {q.shreg[6:0], 1'h0};
            d.cnt = q.cnt + 4'h1;
          end
        end
        default: begin
          d.sda_drive = 1'h0;
        end
      endcase
    end
    // Reserved positions stay zero because they are never assigned.
    d.view = `PCSR_REG_RESET;
    d.view[`PCSR_BIT_MON2] = q.flags[1];
    d.view[`PCSR_BIT_MON3] = q.flags[0];
    d.view[`PCSR_BIT_LOCK] = q.lock;
    d.view[`PCSR_BIT_REGISTER_WRITE_UNLOCK] = q.register_write_unlock;
    d.view[`PCSR_BIT_WEL] = q.global_write_latch;
    d.vol_ok = q.global_write_latch & ~q.lock;
    d.nv_ok = q.global_write_latch & ~q.lock & ~pins.wp;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // The lock is nonvolatile, so reset reloads it from the storage cell
  // rather than clearing it.
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.state <= pcsr_pkg::pcsr_st_idle;
      q.nxt <= pcsr_pkg::pcsr_st_idle;
      q.lock <= nv_lock_recall;
    end else if (ce) begin
      q <= d;
    end
  end

  assign sda_out = 1'h0;
  assign sda_oe_n = ~q.sda_drive;
  assign control_status = q.view;
  assign pot_volatile_write_ok = q.vol_ok;
  assign pot_nonvolatile_write_ok = q.nv_ok;
  assign nv_store_pulse = q.nv_store;
  assign nv_store_data = q.nv_data;
  assign nv_busy = busy;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_unlock_needs_latch: assert property (
    $rose(q.register_write_unlock) |-> $past(q.global_write_latch))
    else $error("unlock bit set without the latch");

  a_no_latch_nack: assert property (
    (ce && evt.fall && q.state == pcsr_pkg::pcsr_st_data &&
     q.cnt == `PCSR_BYTE_BITS && !q.global_write_latch && q.shreg != `PCSR_CMD_SET_WEL &&
     q.shreg != `PCSR_CMD_CLR_WEL) |=> !q.sda_drive ##1 !q.pending)
    else $error("data byte acked with latch clear");

  a_second_byte_nack: assert property (
    (ce && evt.fall && q.state == pcsr_pkg::pcsr_st_data &&
     q.cnt == `PCSR_BYTE_BITS && q.pending) |=> (!q.sda_drive && !q.pending))
    else $error("second data byte acked");

  a_busy_addr_nack: assert property (
    (ce && busy && evt.fall && q.state == pcsr_pkg::pcsr_st_addr &&
     q.cnt == `PCSR_BYTE_BITS) |=> !q.sda_drive)
    else $error("address acked during store cycle");

  a_latch_no_store: assert property (
    (ce && evt.stop && q.pending && !q.register_write_unlock && !busy) |=> !busy)
    else $error("latch write started a store cycle");

  a_store_starts: assert property (
    (ce && evt.stop && q.pending && q.register_write_unlock && !busy &&
     !q.pend[`PCSR_BIT_REGISTER_WRITE_UNLOCK] && !pins.wp) |=> busy [*8])
    else $error("store cycle did not start");

  a_protect_no_store: assert property (
    (ce && evt.stop && !busy && pins.wp) |=> !busy)
    else $error("store cycle started under protect pin");

  a_flag_follows: assert property (
    (ce && !pins.mon[1]) |=> !q.flags[1])
    else $error("monitor two flag held with output low");

  a_flag_set_high: assert property (
    $rose(q.flags[0]) |-> $past(pins.mon[0]))
    else $error("monitor three flag set with output low");

  a_reserved_zero: assert property (
    (q.view & `PCSR_RSVD_MASK) == `PCSR_REG_RESET)
    else $error("reserved bit read as one");

  a_lock_blocks: assert property (
    (ce && q.lock && !evt.stop) |=> !q.vol_ok)
    else $error("pot write allowed while locked");

  c_latch_set: cover property ($rose(q.global_write_latch));
  c_unlock_set: cover property ($rose(q.register_write_unlock));
  c_store_done: cover property (q.nv_store);
  c_read_done: cover property (
    q.state == pcsr_pkg::pcsr_st_read ##1
    q.state == pcsr_pkg::pcsr_st_wait);

endmodule : pcsr_control_status

// ===== pcsr_master_model.sv
`timescale 1ns/1ns
module pcsr_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel,
  output logic res_v,
  output logic [7:0] res
);
  // --------------------------------------------------------------------
  // Bus phases
  // --------------------------------------------------------------------
  // Every phase lasts five clocks, so each level outlives the two-flop
  // synchronisers of the device before the next change.
  initial begin
    scl = 1'h1;
    sda_rel = 1'h1;
    res_v = 1'h0;
    res = 8'h00;
  end

  always @(posedge clk) begin
    if (res_v) begin
      res_v <= 1'h0;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic start;
    tick(1);
    sda_rel <= 1'h1;
    tick(4);
    scl <= 1'h1;
    tick(5);
    sda_rel <= 1'h0;
    tick(5);
    scl <= 1'h0;
  endtask : start

  task automatic stop;
    tick(1);
    sda_rel <= 1'h0;
    tick(4);
    scl <= 1'h1;
    tick(5);
    sda_rel <= 1'h1;
    tick(5);
  endtask : stop

  // Data moves only while the clock is low, so no false frame edge.
  task automatic clk_bit(input logic b, output logic s);
    tick(1);
    sda_rel <= b;
    tick(4);
    scl <= 1'h1;
    tick(5);
    s = sda_line;
    scl <= 1'h0;
  endtask : clk_bit

  task automatic report(input logic [7:0] v);
    res <= v;
    res_v <= 1'h1;
  endtask : report

  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'h1, s);
    report({7'h00, s});
  endtask : send

  task automatic recv;
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'h1, s);
      v[i] = s;
    end
    clk_bit(1'h1, s);
    report(v);
  endtask : recv
endmodule : pcsr_master_model

// ===== pot_control_status_register_tb.sv
`timescale 1ns/1ns
`include "pcsr_map.svh"
module pot_control_status_register_tb;
  logic clk = 1'h0;
  logic srst;
  logic ce;
  logic wp_pin;
  logic [1:0] mon;
  logic recall;
  wire logic sda_line;
  logic scl;
  logic sda_rel;
  logic res_v;
  logic [7:0] res;
  logic sda_out;
  logic sda_oe_n;
  logic vol_ok;
  logic nv_ok;
  logic nv_busy;
  logic [7:0] cs;
  logic nv_pulse;
  logic nv_data;
  int n_pulse = 0;
  logic [7:0] exp_q[$];
  logic [16:0] seed = 17'h17A6D;
  logic [7:0] d;
  int num_errors = 0;
  int n_tests = 0;

  always #5 clk = ~clk;
  // Pull-up line: low while either party pulls it.
  assign sda_line = sda_rel & (sda_oe_n | sda_out);

  pcsr_control_status #(.NV_CYCLES(400)) i_pcsr_control_status (
    .clk(clk), .srst(srst), .ce(ce), .scl_pin(scl), .sda_pin(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wp_pin(wp_pin),
    .monitor_reset_out(mon), .nv_lock_recall(recall),
    .control_status(cs), .pot_volatile_write_ok(vol_ok),
    .pot_nonvolatile_write_ok(nv_ok), .nv_store_pulse(nv_pulse),
    .nv_store_data(nv_data), .nv_busy(nv_busy)
  );

  pcsr_master_model i_pcsr_master_model (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel),
    .res_v(res_v), .res(res)
  );

  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic check(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check

  // Each store cycle must end in exactly one pulse.
  always @(posedge clk) begin
    if (nv_pulse === 1'h1) begin
      n_pulse++;
    end
  end

  always @(posedge clk) begin
    if (res_v === 1'h1) begin
      if (exp_q.size() == 0) begin
        check(8'hEE, res);
      end else begin
        check(exp_q.pop_front(), res);
      end
    end
  end

  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic endt(input string s);
    check(8'h00, 8'(exp_q.size()));
    $display("end of test %s", s);
  endtask : endt

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  // --------------------------------------------------------------------
  // Bus operations
  // --------------------------------------------------------------------
  task automatic put(input logic [7:0] v);
    exp_q.push_back(v);
  endtask : put

  // A second copy of the data byte is sent when two is set.
  task automatic wr(input logic [7:0] d, input logic [7:0] a,
                    input logic two = 1'h0);
    put(8'h00);
    put(8'h00);
    put(a);
    i_pcsr_master_model.start();
    i_pcsr_master_model.send(`PCSR_ADDR_WR);
    i_pcsr_master_model.send(`PCSR_REG_OFFSET);
    i_pcsr_master_model.send(d);
    if (two) begin
      put(8'h01);
      i_pcsr_master_model.send(d);
    end
    i_pcsr_master_model.stop();
  endtask : wr

  task automatic rd(input logic [7:0] e);
    put(8'h00);
    put(8'h00);
    put(8'h00);
    put(e);
    i_pcsr_master_model.start();
    i_pcsr_master_model.send(`PCSR_ADDR_WR);
    i_pcsr_master_model.send(`PCSR_REG_OFFSET);
    i_pcsr_master_model.start();
    i_pcsr_master_model.send(`PCSR_ADDR_RD);
    i_pcsr_master_model.recv();
    i_pcsr_master_model.stop();
  endtask : rd

  task automatic wait_nv;
    int n;
    n = 0;
    while (nv_busy !== 1'h0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      num_errors++;
      $display("[ERR] t=%0t busy exp=0 got=%h", $time, nv_busy);
      print_verdict();
    end
  endtask : wait_nv

  task automatic rst(input logic r);
    recall <= r;
    srst <= 1'h1;
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : rst

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    srst <= 1'h1;
    ce <= 1'h1;
    wp_pin <= 1'h0;
    mon <= 2'h3;
    recall <= 1'h0;
    rst(1'h0);
    rd(8'h00);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d = {6'h00, seed[0], 1'h0};
      mon <= seed[2:1];
      wr(d, 8'h00);
      rd(d);
    end
    endt("latch");
    mon <= 2'h3;
    wr(8'h00, 8'h00);
    wr(8'h06, 8'h01);
    rd(8'h00);
    endt("refused");
    wr(8'h02, 8'h00);
    check(8'h00, {7'h00, nv_busy});
    wr(8'h06, 8'h00);
    rd(8'h06);
    wr(8'h6A, 8'h00);
    put(8'h01);
    i_pcsr_master_model.start();
    i_pcsr_master_model.send(`PCSR_ADDR_WR);
    i_pcsr_master_model.stop();
    wait_nv();
    rd(8'h6A);
    check(8'h6A, cs);
    check(8'h01, {7'h00, nv_data});
    check(8'h01, 8'(n_pulse));
    check(8'h00, {6'h00, nv_ok, vol_ok});
    endt("store");
    mon <= 2'h1;
    repeat (5) @(posedge clk);
    rd(8'h2A);
    wr(8'h06, 8'h00);
    wr(8'h66, 8'h00);
    check(8'h00, {7'h00, nv_busy});
    rd(8'h2E);
    wr(8'h02, 8'h00, 1'h1);
    rd(8'h2E);
    endt("unlock");
    wp_pin <= 1'h1;
    wr(8'h02, 8'h01);
    rd(8'h2E);
    wp_pin <= 1'h0;
    wr(8'h83, 8'h01);
    wr(8'h02, 8'h00);
    wait_nv();
    rd(8'h02);
    check(8'h02, 8'(n_pulse));
    check(8'h00, {7'h00, nv_data});
    check(8'h03, {6'h00, nv_ok, vol_ok});
    wp_pin <= 1'h1;
    repeat (5) @(posedge clk);
    check(8'h01, {6'h00, nv_ok, vol_ok});
    // With the enable low the protect pin must not reach the outputs.
    ce <= 1'h0;
    wp_pin <= 1'h0;
    repeat (5) @(posedge clk);
    check(8'h01, {6'h00, nv_ok, vol_ok});
    ce <= 1'h1;
    repeat (5) @(posedge clk);
    check(8'h03, {6'h00, nv_ok, vol_ok});
    endt("protect");
    rst(1'h1);
    rd(8'h08);
    check(8'h08, cs);
    endt("recall");
    print_verdict();
  end
endmodule : pot_control_status_register_tb
